//--- pkg/ssp_pkg.sv
package ssp_pkg;
  localparam logic [7:0] CTRL_OFS = 8'h14;
  localparam logic [7:0] STAT_OFS = 8'h94;
  localparam logic [7:0] BUF_OFS  = 8'h18;
  localparam logic [7:0] DIR_OFS  = 8'h1c;
  localparam logic [7:0] FLAG_OFS = 8'h20;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DIR_RST  = 8'hff;
  localparam int CTRL_WRITE_COLLISION  = 7;
  localparam int CTRL_OVF   = 6;
  localparam int CTRL_EN    = 5;
  localparam int CTRL_CPOL  = 4;
  localparam int STAT_BF    = 0;
  localparam int STAT_START = 3;
  localparam int STAT_STOP  = 4;
  localparam int DIR_SS     = 0;
  localparam int DIR_SCK    = 3;
  localparam int DIR_SDI    = 4;
  localparam int DIR_SDO    = 5;
  localparam logic [3:0] MODE_DIV4   = 4'h0;
  localparam logic [3:0] MODE_DIV16  = 4'h1;
  localparam logic [3:0] MODE_DIV64  = 4'h2;
  localparam logic [3:0] MODE_TIMER_TWO   = 4'h3;
  localparam logic [3:0] MODE_SLV_SS = 4'h4;
  localparam logic [3:0] MODE_SLV    = 4'h5;
  localparam logic [3:0] MODE_TW7    = 4'h6;
  localparam logic [3:0] MODE_TW10   = 4'h7;
  localparam logic [3:0] MODE_TWFW   = 4'hb;
  localparam logic [3:0] MODE_TW7I   = 4'he;
  localparam logic [3:0] MODE_TW10I  = 4'hf;
  localparam logic [5:0] HALF_DIV4   = 6'h02;
  localparam logic [5:0] HALF_DIV16  = 6'h08;
  localparam logic [5:0] HALF_DIV64  = 6'h20;
  localparam logic [3:0] LAST_EDGE   = 4'hf;
  localparam logic [2:0] LAST_BIT    = 3'h7;
  typedef enum logic [0:0] {
    MST_IDLE = 1'b0,
    MST_RUN  = 1'b1
  } mst_state_e;
endpackage : ssp_pkg

//--- pkg/shift_if.sv
`timescale 1ns/100ps
interface shift_if;
  logic       load;
  logic [7:0] load_byte;
  logic       clear;
  logic       tx_edge;
  logic       rx_edge;
  logic       rx_bit;
  logic       tx_bit;
  logic       done;
  logic       busy;
  logic [7:0] rx_byte;
  modport core (output load, load_byte, clear, tx_edge, rx_edge, rx_bit,
                input tx_bit, done, busy, rx_byte);
  modport shifter (input load, load_byte, clear, tx_edge, rx_edge, rx_bit,
                   output tx_bit, done, busy, rx_byte);
endinterface : shift_if

//--- core/ssp_shifter.sv
`timescale 1ns/100ps
module ssp_shifter (
  input wire logic clk_i,
  input wire logic rst_i,
  shift_if.shifter sh
);
  logic [7:0] sr_q;
  logic [2:0] cnt_q;
  logic       tx_q;
  logic       done_q;
  logic       busy_q;
  logic       last_w;

  assign last_w     = sh.rx_edge && (cnt_q == ssp_pkg::LAST_BIT);
  assign sh.tx_bit  = tx_q;
  assign sh.done    = done_q;
  assign sh.busy    = busy_q;
  assign sh.rx_byte = sr_q;

  // One register serves both directions: the bit sent leaves the top as
  // the bit sampled enters the bottom.
  always_ff @(posedge clk_i) begin
    if (rst_i || sh.clear) begin
      sr_q <= 8'h00;
    end else if (sh.load) begin
      sr_q <= sh.load_byte;
    end else if (sh.rx_edge) begin
      sr_q <= {sr_q[6:0], sh.rx_bit};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || sh.clear || sh.load) begin
      cnt_q <= 3'h0;
    end else if (sh.rx_edge) begin
      cnt_q <= cnt_q + 3'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || sh.clear) begin
      tx_q <= 1'b0;
    end else if (sh.load) begin
      tx_q <= sh.load_byte[7];
    end else if (sh.tx_edge) begin
      tx_q <= sr_q[7];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || sh.clear) begin
      done_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      done_q <= last_w;
      if (last_w) begin
        busy_q <= 1'b0;
      end else if (sh.load || sh.tx_edge || sh.rx_edge) begin
        busy_q <= 1'b1;
      end
    end
  end

  a_msb_first: assert property (@(posedge clk_i) disable iff (rst_i)
    sh.tx_edge && !sh.clear && !sh.load |=> tx_q == $past(sr_q[7]))
    else $error("sent bit is not the top of the shift register");
endmodule : ssp_shifter

//--- core/ssp_core.sv
`timescale 1ns/100ps
module ssp_core (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        sck_in_i,
  output logic             sck_o,
  output logic             sck_oe_o,
  input  wire logic        sdi_i,
  output logic             sdo_o,
  output logic             sdo_oe_o,
  input  wire logic        ss_n_i,
  input  wire logic        timer_two_tick_i,
  input  wire logic        tw_start_i,
  input  wire logic        tw_stop_i,
  output logic             tw_sel_o,
  output logic      [3:0]  tw_mode_o,
  output logic             irq_o
);
  // ==========================================================
  // Register state
  logic       write_collision_q;
  logic       ovf_q;
  logic       en_q;
  logic       cpol_q;
  logic [3:0] mode_q;
  logic [7:0] dir_q;
  logic [7:0] buf_q;
  logic       bf_q;
  logic       flag_q;
  logic       start_q;
  logic       stop_q;
  logic       ack_q;
  logic [7:0] rdat_q;
  logic [7:0] rdat_d;

  // ==========================================================
  // Serial state
  ssp_pkg::mst_state_e mst_q;
  logic       sck_q;
  logic [5:0] half_q;
  logic [3:0] edge_q;
  logic       pin_q;
  logic       sdo_q;
  logic       sdo_oe_q;
  logic       sck_oe_q;
  logic       tw_sel_q;

  logic       req_w;
  logic       wr_w;
  logic       rd_w;
  logic       ctrl_wr;
  logic       buf_wr;
  logic       buf_rd;
  logic       is_master;
  logic       is_slave;
  logic       is_tw;
  logic       spi_on;
  logic       load_w;
  logic       write_collision_set;
  logic       drop_w;
  logic       take_w;
  logic [5:0] half_lim;
  logic       tick_w;
  logic       m_lead;
  logic       m_trail;
  logic       s_sel;
  logic       s_lead;
  logic       s_trail;

  shift_if sh ();

  ssp_shifter u_shifter (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .sh    (sh.shifter)
  );

  // ==========================================================
  // Bus decode
  // Only byte lane 0 carries register data, so a write without it is
  // acknowledged and changes nothing.
  assign req_w   = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr_w    = req_w && wb_we_i && wb_sel_i[0];
  assign rd_w    = req_w && !wb_we_i;
  assign ctrl_wr = wr_w && (wb_adr_i == ssp_pkg::CTRL_OFS);
  assign buf_wr  = wr_w && (wb_adr_i == ssp_pkg::BUF_OFS);
  assign buf_rd  = rd_w && (wb_adr_i == ssp_pkg::BUF_OFS);

  // ==========================================================
  // Mode decode
  assign is_master = (mode_q <= ssp_pkg::MODE_TIMER_TWO);
  assign is_slave  = (mode_q == ssp_pkg::MODE_SLV_SS) ||
                     (mode_q == ssp_pkg::MODE_SLV);
  assign is_tw     = (mode_q == ssp_pkg::MODE_TW7) ||
                     (mode_q == ssp_pkg::MODE_TW10) ||
                     (mode_q == ssp_pkg::MODE_TWFW) ||
                     (mode_q == ssp_pkg::MODE_TW7I) ||
                     (mode_q == ssp_pkg::MODE_TW10I);
  assign spi_on    = en_q && (is_master || is_slave);

  assign write_collision_set = buf_wr && spi_on && sh.busy;
  assign load_w   = buf_wr && spi_on && !sh.busy;
  // A slave cannot hold off its master, so a byte that finds the buffer
  // still full is lost; a master never starts one without a buffer write.
  assign drop_w   = is_slave && bf_q;
  assign take_w   = sh.done && !drop_w;

  // ==========================================================
  // Control and direction registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_q   <= ssp_pkg::CTRL_RST[ssp_pkg::CTRL_EN];
      cpol_q <= ssp_pkg::CTRL_RST[ssp_pkg::CTRL_CPOL];
      mode_q <= ssp_pkg::CTRL_RST[3:0];
    end else if (ctrl_wr) begin
      en_q   <= wb_dat_i[ssp_pkg::CTRL_EN];
      cpol_q <= wb_dat_i[ssp_pkg::CTRL_CPOL];
      mode_q <= wb_dat_i[3:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      write_collision_q <= ssp_pkg::CTRL_RST[ssp_pkg::CTRL_WRITE_COLLISION];
    end else if (write_collision_set) begin
      write_collision_q <= 1'b1;
    end else if (ctrl_wr) begin
      write_collision_q <= wb_dat_i[ssp_pkg::CTRL_WRITE_COLLISION];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovf_q <= ssp_pkg::CTRL_RST[ssp_pkg::CTRL_OVF];
    end else if (sh.done && drop_w) begin
      ovf_q <= 1'b1;
    end else if (ctrl_wr) begin
      ovf_q <= wb_dat_i[ssp_pkg::CTRL_OVF];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dir_q <= ssp_pkg::DIR_RST;
    end else if (wr_w && (wb_adr_i == ssp_pkg::DIR_OFS)) begin
      dir_q <= wb_dat_i[7:0];
    end
  end

  // ==========================================================
  // Buffer, status and flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      buf_q <= 8'h00;
    end else if (take_w) begin
      buf_q <= sh.rx_byte;
    end else if (buf_wr && !write_collision_set) begin
      buf_q <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !en_q) begin
      bf_q <= 1'b0;
    end else if (take_w) begin
      bf_q <= 1'b1;
    end else if (buf_rd) begin
      bf_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_q <= 1'b0;
    end else if (take_w) begin
      flag_q <= 1'b1;
    end else if (wr_w && (wb_adr_i == ssp_pkg::FLAG_OFS) && wb_dat_i[0]) begin
      flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !en_q) begin
      start_q <= 1'b0;
      stop_q  <= 1'b0;
    end else if (is_tw && tw_start_i) begin
      start_q <= 1'b1;
      stop_q  <= 1'b0;
    end else if (is_tw && tw_stop_i) begin
      start_q <= 1'b0;
      stop_q  <= 1'b1;
    end
  end

  // ==========================================================
  // Bus answer
  always_comb begin
    rdat_d = 8'h00;
    unique case (wb_adr_i)
      ssp_pkg::CTRL_OFS: rdat_d = {write_collision_q, ovf_q, en_q, cpol_q, mode_q};
      ssp_pkg::STAT_OFS: rdat_d = {3'h0, stop_q, start_q, 2'h0, bf_q};
      ssp_pkg::BUF_OFS:  rdat_d = buf_q;
      ssp_pkg::DIR_OFS:  rdat_d = dir_q;
      ssp_pkg::FLAG_OFS: rdat_d = {7'h00, flag_q};
      default:           rdat_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q  <= 1'b0;
      rdat_q <= 8'h00;
    end else begin
      ack_q  <= req_w;
      rdat_q <= rd_w ? rdat_d : 8'h00;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = {24'h000000, rdat_q};

  // ==========================================================
  // Master clock generator
  always_comb begin
    unique case (mode_q)
      ssp_pkg::MODE_DIV16: half_lim = ssp_pkg::HALF_DIV16;
      ssp_pkg::MODE_DIV64: half_lim = ssp_pkg::HALF_DIV64;
      default:             half_lim = ssp_pkg::HALF_DIV4;
    endcase
  end

  // Each tick ends one half bit period; timer two ticks toggle directly,
  // which halves the timer rate.
  assign tick_w  = (mode_q == ssp_pkg::MODE_TIMER_TWO) ? timer_two_tick_i :
                   (half_q == half_lim - 6'h01);
  assign m_lead  = (mst_q == ssp_pkg::MST_RUN) && tick_w &&
                   (sck_q == cpol_q);
  assign m_trail = (mst_q == ssp_pkg::MST_RUN) && tick_w &&
                   (sck_q != cpol_q);

  always_ff @(posedge clk_i) begin
    if (rst_i || !spi_on || !is_master) begin
      mst_q  <= ssp_pkg::MST_IDLE;
      sck_q  <= cpol_q;
      half_q <= 6'h00;
      edge_q <= 4'h0;
    end else begin
      unique case (mst_q)
        ssp_pkg::MST_IDLE: begin
          sck_q  <= cpol_q;
          half_q <= 6'h00;
          edge_q <= 4'h0;
          if (load_w) begin
            mst_q <= ssp_pkg::MST_RUN;
          end
        end
        ssp_pkg::MST_RUN: begin
          half_q <= tick_w ? 6'h00 : half_q + 6'h01;
          if (tick_w) begin
            sck_q  <= ~sck_q;
            edge_q <= edge_q + 4'h1;
            if (edge_q == ssp_pkg::LAST_EDGE) begin
              mst_q <= ssp_pkg::MST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Slave clock edges
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= sck_in_i;
    end
  end

  // Select raised freezes the edges and floats data-out but clears nothing, so the
  // shifter keeps its place and carries on mid-byte when select falls again.
  assign s_sel   = (mode_q != ssp_pkg::MODE_SLV_SS) ||
                   !dir_q[ssp_pkg::DIR_SS] || !ss_n_i;
  assign s_lead  = spi_on && is_slave && s_sel && dir_q[ssp_pkg::DIR_SCK] &&
                   (pin_q == cpol_q) && (sck_in_i != cpol_q);
  assign s_trail = spi_on && is_slave && s_sel && dir_q[ssp_pkg::DIR_SCK] &&
                   (pin_q != cpol_q) && (sck_in_i == cpol_q);

  assign sh.load      = load_w;
  assign sh.load_byte = wb_dat_i[7:0];
  assign sh.clear     = !spi_on;
  assign sh.tx_edge   = m_lead || s_lead;
  assign sh.rx_edge   = m_trail || s_trail;
  assign sh.rx_bit    = dir_q[ssp_pkg::DIR_SDI] && sdi_i;

  // ==========================================================
  // Pin drivers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sdo_q    <= 1'b0;
      sdo_oe_q <= 1'b0;
      sck_oe_q <= 1'b0;
      tw_sel_q <= 1'b0;
    end else begin
      sdo_q    <= sh.tx_bit;
      sdo_oe_q <= spi_on && !dir_q[ssp_pkg::DIR_SDO] &&
                  s_sel;
      sck_oe_q <= spi_on && is_master &&
                  !dir_q[ssp_pkg::DIR_SCK];
      tw_sel_q <= en_q && is_tw;
    end
  end

  assign sck_o     = sck_q;
  assign sck_oe_o  = sck_oe_q;
  assign sdo_o     = sdo_q;
  assign sdo_oe_o  = sdo_oe_q;
  assign tw_sel_o  = tw_sel_q;
  assign tw_mode_o = mode_q;
  assign irq_o     = flag_q;

  // ==========================================================
  // Checks
  logic [3:0] lead_cnt_q;
  always_ff @(posedge clk_i) begin
    if (rst_i || load_w) begin
      lead_cnt_q <= 4'h0;
    end else if (m_lead) begin
      lead_cnt_q <= lead_cnt_q + 4'h1;
    end
  end

  sequence s_byte_start;
    load_w && is_master;
  endsequence

  sequence s_run_begins;
    ##1 (mst_q == ssp_pkg::MST_RUN);
  endsequence

  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");

  a_master_start: assert property (@(posedge clk_i)
    disable iff (rst_i) s_byte_start |-> s_run_begins)
    else $error("buffer write did not start a master byte");

  a_eight_pulses: assert property (@(posedge clk_i)
    disable iff (rst_i) $fell(mst_q == ssp_pkg::MST_RUN) && spi_on &&
    is_master |-> lead_cnt_q == 4'h8)
    else $error("master byte did not give eight clock pulses");

  // A control write may move the idle level, so it is left out here.
  a_sck_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    (mst_q == ssp_pkg::MST_IDLE) && !load_w && !ctrl_wr |=> sck_q == cpol_q)
    else $error("serial clock not at its idle level");

  a_write_collision_set: assert property (@(posedge clk_i) disable iff (rst_i)
    buf_wr && spi_on && sh.busy |=> write_collision_q && $stable(buf_q))
    else $error("collision write not flagged");

  a_bf_on_done: assert property (@(posedge clk_i)
    disable iff (rst_i) sh.done && en_q && !drop_w |=> bf_q && flag_q &&
    buf_q == $past(sh.rx_byte))
    else $error("completed byte not placed in buffer");

  a_bf_read_clr: assert property (@(posedge clk_i)
    disable iff (rst_i) buf_rd && !sh.done |=> !bf_q)
    else $error("buffer read did not clear buffer full");

  a_ovf_slave: assert property (@(posedge clk_i) disable iff (rst_i)
    sh.done && is_slave && bf_q |=> ovf_q && $stable(buf_q))
    else $error("overflow not flagged or byte not dropped");

  a_ovf_master: assert property (@(posedge clk_i) disable iff (rst_i)
    is_master && !ctrl_wr |=> !$rose(ovf_q))
    else $error("overflow set in master operation");

  a_tw_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    !en_q |=> !start_q && !stop_q)
    else $error("start or stop status kept while disabled");
endmodule : ssp_core

//--- testbench/spi_peer.sv
`timescale 1ns/100ps
module spi_peer (
  input  wire logic       clk_i,
  input  wire logic       sync_i,
  input  wire logic       sck_i,
  input  wire logic       cpol_i,
  input  wire logic       mosi_i,
  input  wire logic [7:0] tx_i,
  output logic            miso_o,
  output logic      [7:0] rx_o
);
  logic       prev_q;
  logic [2:0] idx_q;
  // Edges are seen one clock late, so the port's launched data has settled.
  always_ff @(posedge clk_i) begin
    prev_q <= sck_i;
    if (sync_i) begin
      idx_q  <= 3'h0;
      miso_o <= ~tx_i[7];
    end else if (sck_i !== prev_q && sck_i !== cpol_i) begin
      miso_o <= tx_i[3'h7 - idx_q];
    end else if (sck_i !== prev_q) begin
      rx_o  <= {rx_o[6:0], mosi_i};
      idx_q <= idx_q + 3'h1;
      // Past the last bit the line no longer holds valid data.
      if (idx_q == 3'h7) miso_o <= ~miso_o;
    end
  end
endmodule : spi_peer

//--- testbench/ssp_core_bench.sv
`timescale 1ns/100ps
module ssp_core_bench;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic [7:0]  adr = 0, p_tx = 0, p_rx, b_tx = 0, b_rx = 0, q;
  logic [31:0] wdat = 0, rdat;
  logic        ack, sck, sck_oe, serial_data_out, sdo_oe, tw_sel, irq, miso, sp;
  logic [3:0]  tw_mode;
  logic        b_sck = 0, b_sdi = 0, ss_n = 1, tick = 0, tws = 0;
  logic        slv = 0, sync = 0, cp = 0, twp = 0;
  logic [3:0]  sel = 0, lane = 4'h1;
  int          n_fail = 0, compares = 0, tog = 0, t0, t1, cc = 0;
  int          bi, tc = 0;
  int          hv[4] = '{2, 8, 32, 3};
  logic [3:0]  twm[5] = '{4'h6, 4'h7, 4'hb, 4'he, 4'hf};

  ssp_core DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .sck_in_i(b_sck),
    .sck_o(sck), .sck_oe_o(sck_oe), .sdi_i(slv ? b_sdi : miso),
    .sdo_o(serial_data_out), .sdo_oe_o(sdo_oe), .ss_n_i(ss_n), .timer_two_tick_i(tick),
    .tw_start_i(tws), .tw_stop_i(twp), .tw_sel_o(tw_sel),
    .tw_mode_o(tw_mode), .irq_o(irq));
  spi_peer peer (.clk_i(clk_i), .sync_i(sync), .sck_i(sck), .cpol_i(cp),
    .mosi_i(serial_data_out), .tx_i(p_tx), .miso_o(miso), .rx_o(p_rx));

  // ====
  // Clock, timer ticks and edge monitor.
  initial forever #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    tc   <= (tc == 2) ? 0 : tc + 1;
    tick <= (tc == 2);
    cc++;
    if (sck !== sp) begin
      tog++;
      if (tog == 1) t0 = cc;
      t1 = cc;
    end
    sp = sck;
  end

  // ====
  // Access tasks.
  task chk(input string nm, input logic [31:0] got, input logic [31:0] e);
    compares++;
    if (got !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, got);
    end
  endtask : chk
  task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc  <= 1;
    stb  <= 1;
    we   <= w;
    adr  <= a;
    wdat <= {24'h0, d};
    sel  <= lane;
    @(posedge clk_i);
    // Only the watchdog ends a wait for an answer that never comes.
    while (ack !== 1'b1) @(posedge clk_i);
    q = rdat[7:0];
    cyc <= 0;
    stb <= 0;
  endtask : wb
  task waitbf();
    for (int i = 0; i < 400; i++) begin
      wb(0, ssp_pkg::STAT_OFS, 0);
      if (q[0] === 1'b1) break;
    end
  endtask : waitbf
  task xfer(input logic [7:0] tx);
    @(posedge clk_i) sync <= 1;
    @(posedge clk_i) sync <= 0;
    tog = 0;
    wb(1, ssp_pkg::BUF_OFS, tx);
    for (int i = 0; i < 2000 && tog < 16; i++) @(posedge clk_i);
    waitbf();
  endtask : xfer
  task sbits(input int n);
    // Data moves with the leading edge so it stands at the trailing one.
    repeat (n) begin
      repeat (6) @(posedge clk_i);
      b_sck <= 1;
      b_sdi <= b_tx[7-bi];
      repeat (6) @(posedge clk_i);
      b_rx = {b_rx[6:0], serial_data_out};
      b_sck <= 0;
      bi++;
    end
  endtask : sbits
  task results();
    if (n_fail == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results

  initial begin
    repeat (60000) @(posedge clk_i);
    n_fail++;
    results();
  end

  // ====
  // Tests.
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    wb(0, ssp_pkg::CTRL_OFS, 0);
    chk("ctrl reset", q, 8'h00);
    wb(0, ssp_pkg::STAT_OFS, 0);
    chk("status reset", q, 8'h00);
    wb(0, ssp_pkg::DIR_OFS, 0);
    chk("dir reset", q, 8'hff);
    wb(0, 8'h40, 0);
    chk("unmapped", q, 8'h00);
    wb(1, ssp_pkg::DIR_OFS, 8'hd7);
    lane = 4'h0;
    wb(1, ssp_pkg::DIR_OFS, 8'h00);
    lane = 4'h1;
    wb(0, ssp_pkg::DIR_OFS, 0);
    chk("lane 0 off", q, 8'hd7);
    for (int m = 0; m < 4; m++) begin
      cp <= m[0];
      p_tx <= 8'hc3 ^ m[7:0];
      wb(1, ssp_pkg::CTRL_OFS, m[7:0]);
      wb(1, ssp_pkg::CTRL_OFS, {2'b00, 1'b1, m[0], m[3:0]});
      xfer(8'ha5 + m[7:0]);
      chk("toggles", tog, 16);
      chk("rate", t1 - t0, 15 * hv[m]);
      chk("idle", sck, cp);
      chk("sck oe", sck_oe, 1'b1);
      chk("sdo oe", sdo_oe, 1'b1);
      chk("peer rx", p_rx, 8'ha5 + m[7:0]);
      chk("irq", irq, 1'b1);
      wb(0, ssp_pkg::BUF_OFS, 0);
      chk("rx byte", q, 8'hc3 ^ m[7:0]);
      wb(0, ssp_pkg::STAT_OFS, 0);
      chk("bf clear", q[0], 1'b0);
      wb(1, ssp_pkg::FLAG_OFS, 8'h01);
      chk("irq clear", irq, 1'b0);
    end
    @(posedge clk_i) sync <= 1;
    @(posedge clk_i) sync <= 0;
    tog = 0;
    wb(1, ssp_pkg::BUF_OFS, 8'h3c);
    wb(1, ssp_pkg::BUF_OFS, 8'hff);
    wb(0, ssp_pkg::CTRL_OFS, 0);
    chk("collision", q[7], 1'b1);
    for (int i = 0; i < 2000 && tog < 16; i++) @(posedge clk_i);
    waitbf();
    chk("peer rx", p_rx, 8'h3c);
    xfer(8'h55);
    wb(0, ssp_pkg::CTRL_OFS, 0);
    chk("no master ovf", q[6], 1'b0);
    chk("write_collision held", q[7], 1'b1);
    wb(1, ssp_pkg::CTRL_OFS, 8'h33);
    wb(0, ssp_pkg::CTRL_OFS, 0);
    chk("ctrl", q, 8'h33);
    wb(0, ssp_pkg::BUF_OFS, 0);
    wb(1, ssp_pkg::DIR_OFS, 8'hc7);
    xfer(8'h0f);
    wb(0, ssp_pkg::BUF_OFS, 0);
    chk("sdi off", q, 8'h00);
    wb(1, ssp_pkg::CTRL_OFS, 8'h00);
    @(posedge clk_i);
    chk("sck oe off", sck_oe, 1'b0);
    chk("sdo oe off", sdo_oe, 1'b0);
    // Slave without select, then an unread byte followed by another.
    slv <= 1;
    cp <= 0;
    wb(1, ssp_pkg::DIR_OFS, 8'hdf);
    wb(1, ssp_pkg::CTRL_OFS, 8'h25);
    @(posedge clk_i);
    chk("slave sck oe", sck_oe, 1'b0);
    wb(1, ssp_pkg::BUF_OFS, 8'h96);
    b_tx = 8'h5a;
    bi = 0;
    sbits(8);
    waitbf();
    chk("slave irq", irq, 1'b1);
    wb(0, ssp_pkg::BUF_OFS, 0);
    chk("slave rx", q, 8'h5a);
    chk("slave tx", b_rx, 8'h96);
    b_tx = 8'hc3;
    bi = 0;
    sbits(8);
    repeat (6) @(posedge clk_i);
    b_tx = 8'h0f;
    bi = 0;
    sbits(8);
    repeat (6) @(posedge clk_i);
    wb(0, ssp_pkg::CTRL_OFS, 0);
    chk("overflow", q[6], 1'b1);
    wb(0, ssp_pkg::BUF_OFS, 0);
    chk("kept byte", q, 8'hc3);
    // Select raised mid-byte must float data-out and pause the shift.
    wb(1, ssp_pkg::CTRL_OFS, 8'h04);
    wb(1, ssp_pkg::CTRL_OFS, 8'h24);
    ss_n <= 0;
    wb(1, ssp_pkg::BUF_OFS, 8'h69);
    b_tx = 8'he1;
    bi = 0;
    sbits(4);
    // Let the fourth trailing edge be taken before select rises.
    repeat (2) @(posedge clk_i);
    ss_n <= 1;
    repeat (3) @(posedge clk_i);
    chk("ss float", sdo_oe, 1'b0);
    ss_n <= 0;
    sbits(4);
    waitbf();
    chk("resume tx", b_rx, 8'h69);
    wb(0, ssp_pkg::BUF_OFS, 0);
    chk("resume rx", q, 8'he1);
    slv <= 0;
    for (int k = 0; k < 5; k++) begin
      wb(1, ssp_pkg::CTRL_OFS, {4'h2, twm[k]});
      @(posedge clk_i);
      chk("tw sel", tw_sel, 1'b1);
      chk("tw mode", tw_mode, twm[k]);
    end
    tws <= 1;
    @(posedge clk_i) tws <= 0;
    wb(0, ssp_pkg::STAT_OFS, 0);
    chk("start bit", q, 8'h08);
    twp <= 1;
    @(posedge clk_i) twp <= 0;
    wb(0, ssp_pkg::STAT_OFS, 0);
    chk("stop bit", q, 8'h10);
    wb(1, ssp_pkg::CTRL_OFS, 8'h00);
    wb(0, ssp_pkg::STAT_OFS, 0);
    chk("start clear", q, 8'h00);
    chk("tw off", tw_sel, 1'b0);
    results();
  end
endmodule : ssp_core_bench
